// >>> tb/reset_controller_regs_tb.sv
// reset_controller_regs_tb: self-checking bench for rstc_regs
// assumes rstc_pin_model on the reset pin and a free-running slow clock
`timescale 1ns/10ps
`default_nettype none
module reset_controller_regs_tb;
    import rstc_pkg::*;
    localparam int SLOW_HALF = 64; // ns, slow period is 16 core cycles
    logic        core_clk   = 1'b0;
    logic        sys_rst    = 1'b1;
    logic        slow_clk   = 1'b0;
    logic [4:0]  addr       = 5'h00;
    logic [31:0] wr_data    = 32'h0;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic        backup_rst = 1'b0;
    logic        wdog_fault = 1'b0;
    logic        ext_low    = 1'b0;
    logic [31:0] rd_data;
    logic        pin_lvl;
    logic        pin_drv;
    logic        pin_oe;
    logic        cpu_rst;
    logic        periph_rst;
    logic        irq;
    int          miscompares = 0;
    int          compares    = 0;

    ////////////////////////////////////////////////////////////////////////
    // clocks: slow clock offset by 3 ns so its edges never meet a core clock edge
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        #3;
        forever #(SLOW_HALF) slow_clk = ~slow_clk;
    end

    rstc_regs dut (
        .core_clk_in(core_clk), .sys_rst_in(sys_rst), .addr_in(addr),
        .wr_data_in(wr_data), .wr_in(wr), .rd_in(rd),
        .rd_data_out(rd_data), .slow_clk_in(slow_clk),
        .backup_rst_in(backup_rst), .wdog_fault_in(wdog_fault),
        .pin_in(pin_lvl), .pin_out(pin_drv), .pin_oe_out(pin_oe),
        .cpu_rst_out(cpu_rst), .periph_rst_out(periph_rst), .irq_out(irq));

    rstc_pin_model pin_model (
        .pin_drv_in(pin_drv), .pin_oe_in(pin_oe), .ext_low_in(ext_low),
        .pin_lvl_out(pin_lvl));

    ////////////////////////////////////////////////////////////////////////
    // closing report, the single exit of the run
    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string what);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                     g, e);
        end
    endtask : chk

    // bus cycles: strobe for one cycle, read data sampled after next edge
    task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr    <= a;
        wr_data <= d;
        wr      <= 1'b1;
        @(posedge core_clk);
        wr      <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1;
        d = rd_data;
    endtask : reg_rd

    function automatic logic sig(input int k);
        case (k)
            0: return cpu_rst;
            1: return periph_rst;
            2: return pin_oe;
            default: return irq;
        endcase
    endfunction : sig

    // bounded wait on an output; a run-out ends the run as a failure
    task automatic wait_for(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while (sig(k) !== v && n < lim) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (sig(k) !== v) begin
            miscompares++;
            $display("CHECK FAILED at %0t: wait on output %0d", $time, k);
            give_verdict();
        end
    endtask : wait_for

    function automatic logic [31:0] exp_sts(input logic e,
            input logic [2:0] c, input logic l, input logic b);
        logic [31:0] w;
        w = 32'h0;
        w[RSTC_EDGE_BIT] = e;
        w[RSTC_CAUSE_LSB +: 3] = c;
        w[RSTC_LEVEL_BIT] = l;
        w[RSTC_BUSY_BIT] = b;
        return w;
    endfunction : exp_sts

    // whole cycles an output stays high once it has risen
    task automatic high_len(input int k, output int n);
        time t0;
        t0 = $time;
        wait_for(k, 1'b0, 4000);
        n = int'(($time - t0) / 8);
    endtask : high_len

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [31:0] got;
        logic [31:0] d;
        logic [31:0] mode_exp;
        logic [3:0]  len;
        int          n;
        int          tk;
        void'($urandom(84));
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        reg_rd(RSTC_STS_OFS, got);
        chk(got, exp_sts(0, RSTC_CAUSE_GEN, 1, 0), "status");
        reg_rd(RSTC_MODE_OFS, got);
        chk(got, 32'h00000001, "mode reset");
        reg_rd(5'h14, got);
        chk(got, 32'h0, "unmapped");
        $display("test reset values done");
        // random mode writes, half of them with a wrong key
        mode_exp = 32'h1;
        for (int i = 0; i < 12; i++) begin
            d = $urandom();
            d[RSTC_PEN_BIT] = 1'b1;
            if (i % 2 == 1) begin
                d[31:24] = RSTC_KEY_VAL;
                mode_exp = d & 32'h00000f11;
            end else if (d[31:24] == RSTC_KEY_VAL) begin
                d[31:24] = 8'h5a;
            end
            reg_wr(RSTC_MODE_OFS, d);
            reg_rd(RSTC_MODE_OFS, got);
            chk(got, mode_exp, "mode write");
        end
        // commands with wrong keys start nothing
        for (int i = 0; i < 4; i++) begin
            d = $urandom() | 32'h0000000d;
            if (d[31:24] == RSTC_KEY_VAL) begin
                d[31:24] = 8'h00;
            end
            reg_wr(RSTC_CMD_OFS, d);
            repeat (6) @(posedge core_clk);
            chk({cpu_rst, periph_rst, pin_oe}, 3'h0, "bad key");
        end
        $display("test keys done");
        // peripheral-only reset, a cpu command while busy is dropped
        reg_wr(RSTC_CMD_OFS, 32'ha5000004);
        wait_for(1, 1'b1, 2);
        reg_wr(RSTC_CMD_OFS, 32'ha5000001);
        reg_rd(RSTC_STS_OFS, got);
        chk(got, exp_sts(0, RSTC_CAUSE_GEN, 1, 1), "busy");
        chk(cpu_rst, 1'b0, "cmd while busy");
        high_len(1, n);
        chk(n >= 28 && n <= 68, 1'b1, "sw length");
        reg_rd(RSTC_STS_OFS, got);
        chk(got, exp_sts(0, RSTC_CAUSE_GEN, 1, 0), "per cause");
        // done event: masked, unmasked, cleared
        reg_rd(RSTC_IRQ_STS_OFS, got);
        chk(got, 32'h2, "done event");
        chk(irq, 1'b0, "masked irq");
        reg_wr(RSTC_IRQ_MSK_OFS, 32'h2);
        wait_for(3, 1'b1, 3);
        reg_wr(RSTC_IRQ_STS_OFS, 32'h2);
        wait_for(3, 1'b0, 3);
        reg_wr(RSTC_IRQ_MSK_OFS, 32'h0);
        $display("test peripheral reset done");
        // processor reset sets the software cause, reads keep it
        reg_wr(RSTC_CMD_OFS, 32'ha5000001);
        wait_for(0, 1'b1, 2);
        high_len(0, n);
        chk(n >= 28 && n <= 68, 1'b1, "cpu length");
        reg_rd(RSTC_STS_OFS, got);
        chk(got, exp_sts(0, RSTC_CAUSE_SW, 1, 0), "sw cause");
        reg_rd(RSTC_STS_OFS, got);
        chk(got, exp_sts(0, RSTC_CAUSE_SW, 1, 0), "cause kept");
        $display("test processor reset done");
        // pin pulse with random length, edge interrupt with pin reset off
        len = 4'($urandom_range(0, 3));
        reg_wr(RSTC_MODE_OFS, {RSTC_KEY_VAL, 12'h0, len, 8'h10});
        reg_wr(RSTC_CMD_OFS, 32'ha5000008);
        wait_for(2, 1'b1, 4);
        high_len(2, n);
        tk = 1 << (len + 1);
        chk(n >= (tk - 1) * 16 && n <= (tk + 1) * 16 + 4, 1'b1,
            "pin length");
        // the three-tick software sequence may outlast a short pin pulse
        repeat (40) @(posedge core_clk);
        chk({irq, cpu_rst}, 2'h2, "edge irq");
        reg_rd(RSTC_STS_OFS, got);
        chk(got, exp_sts(1, RSTC_CAUSE_SW, 1, 0), "edge set");
        wait_for(3, 1'b0, 3);
        reg_rd(RSTC_STS_OFS, got);
        chk(got, exp_sts(0, RSTC_CAUSE_SW, 1, 0), "edge clr");
        // another device holds the line low, pin reset off
        @(posedge core_clk);
        ext_low <= 1'b1;
        repeat (6) @(posedge core_clk);
        reg_rd(RSTC_STS_OFS, got);
        chk(got, exp_sts(1, RSTC_CAUSE_SW, 0, 0), "level low");
        chk(cpu_rst, 1'b0, "no user reset");
        ext_low <= 1'b0;
        repeat (4) @(posedge core_clk);
        reg_rd(RSTC_STS_OFS, got);
        chk(got, exp_sts(0, RSTC_CAUSE_SW, 1, 0), "level high");
        $display("test pin pulse done");
        // user reset from the pin, edge irq must stay quiet
        reg_wr(RSTC_MODE_OFS, 32'ha5000011);
        ext_low <= 1'b1;
        wait_for(0, 1'b1, 6);
        chk({periph_rst, irq}, 2'h2, "user reset");
        repeat (30) @(posedge core_clk);
        ext_low <= 1'b0;
        wait_for(0, 1'b0, 100);
        reg_rd(RSTC_STS_OFS, got);
        chk(got, exp_sts(1, RSTC_CAUSE_USER, 1, 0), "user cause");
        $display("test user reset done");
        // watchdog pulse, then a backup return level
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            if (k == 0) begin
                wdog_fault <= 1'b1;
            end else begin
                backup_rst <= 1'b1;
            end
            repeat (1 + k * 9) @(posedge core_clk);
            wdog_fault <= 1'b0;
            backup_rst <= 1'b0;
            wait_for(0, 1'b1, 4);
            wait_for(0, 1'b0, 100);
            reg_rd(RSTC_STS_OFS, got);
            chk(got[10:8], (k == 0) ? RSTC_CAUSE_WDOG : RSTC_CAUSE_BKUP,
                "hw cause");
        end
        $display("test hardware causes done");
        give_verdict();
    end
endmodule : reset_controller_regs_tb
`default_nettype wire

// >>> tb/rstc_pin_model.sv
// rstc_pin_model: shared reset line with pull-up and other devices on it
// assumes the block drives the line only while its enable is high
`timescale 1ns/10ps
`default_nettype none
module rstc_pin_model (
    // block side of the pin
    input  wire logic pin_drv_in,
    input  wire logic pin_oe_in,
    // other devices pulling the shared line low
    input  wire logic ext_low_in,
    // resolved line level
    output logic      pin_lvl_out
);
    ////////////////////////////////////////////////////////////////////////
    // wired-low line: any low driver wins, else the pull-up holds it high
    always_comb begin
        pin_lvl_out = ~((pin_oe_in & ~pin_drv_in) | ext_low_in);
    end
endmodule : rstc_pin_model
`default_nettype wire

// >>> verilog/rstc_pkg.sv
// rstc_pkg: register map, field positions, reset values and codes
// assumes byte addresses on a plain strobe port, one word per register
package rstc_pkg;

    // register byte offsets
    localparam logic [4:0] RSTC_CMD_OFS     = 5'h00;
    localparam logic [4:0] RSTC_STS_OFS     = 5'h04;
    localparam logic [4:0] RSTC_MODE_OFS    = 5'h08;
    localparam logic [4:0] RSTC_IRQ_STS_OFS = 5'h0c;
    localparam logic [4:0] RSTC_IRQ_MSK_OFS = 5'h10;

    // password field
    localparam int         RSTC_KEY_LSB = 24;
    localparam logic [7:0] RSTC_KEY_VAL = 8'ha5;

    // command bits
    localparam int RSTC_CPU_BIT = 0;
    localparam int RSTC_PER_BIT = 2;
    localparam int RSTC_PIN_BIT = 3;

    // status fields
    localparam int RSTC_EDGE_BIT  = 0;
    localparam int RSTC_CAUSE_LSB = 8;
    localparam int RSTC_LEVEL_BIT = 16;
    localparam int RSTC_BUSY_BIT  = 17;

    // mode fields and reset values
    localparam int         RSTC_PEN_BIT     = 0;
    localparam int         RSTC_PIEN_BIT    = 4;
    localparam int         RSTC_LEN_LSB     = 8;
    localparam logic       RSTC_PEN_RST     = 1'b1;
    localparam logic       RSTC_PIEN_RST    = 1'b0;
    localparam logic [3:0] RSTC_LEN_RST     = 4'h0;

    // interrupt status bits
    localparam int RSTC_IRQ_EDGE = 0;
    localparam int RSTC_IRQ_DONE = 1;

    // reset cause codes
    localparam logic [2:0] RSTC_CAUSE_GEN  = 3'h0;
    localparam logic [2:0] RSTC_CAUSE_BKUP = 3'h1;
    localparam logic [2:0] RSTC_CAUSE_WDOG = 3'h2;
    localparam logic [2:0] RSTC_CAUSE_SW   = 3'h3;
    localparam logic [2:0] RSTC_CAUSE_USER = 3'h4;

    // slow clock tick counts
    localparam logic [1:0] RSTC_HOLD_TICKS = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SW,
        ST_USER,
        ST_HW
    } rstc_state_t;

endpackage : rstc_pkg

// >>> verilog/rstc_pulse.sv
// rstc_pulse: pin reset pulse timer, 2^(len+1) slow ticks long
// assumes tick_in is a one-cycle pulse per slow clock rising edge
`timescale 1ns/10ps
`default_nettype none
module rstc_pulse (
    // clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       sys_rst_in,
    // control
    input  wire logic       go_in,
    input  wire logic       tick_in,
    input  wire logic [3:0] len_in,
    // state
    output logic            active_out
);

    typedef struct packed {
        logic        active;
        logic [16:0] cnt;
    } rstc_pulse_t;

    rstc_pulse_t q, d;
    logic [16:0] last;

    // last tick index of the pulse; len 15 gives 2^16 ticks
    always_comb begin
        last = 17'((17'h1 << (5'(len_in) + 5'h1)) - 17'h1);
        d    = q;
        if (go_in) begin
            d.active = 1'b1;
            d.cnt    = '0;
        end else if (q.active && tick_in) begin
            if (q.cnt == last) begin
                d.active = 1'b0;
            end else begin
                d.cnt = 17'(q.cnt + 17'h1);
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign active_out = q.active;

    property p_pulse_end;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        q.active && tick_in && !go_in && q.cnt == last |=> !q.active;
    endproperty
    a_pulse_end: assert property (p_pulse_end)
        else $error("pin pulse did not end at its length");

endmodule : rstc_pulse
`default_nettype wire

// >>> verilog/rstc_regs.sv
// rstc_regs: reset controller registers, reset sequencing, pin control
// assumes slow_clk_in far slower than core_clk_in, pin wired-low outside
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module rstc_regs
    import rstc_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    // register port
    input  wire logic [4:0]  addr_in,
    input  wire logic [31:0] wr_data_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rd_data_out,
    // reset sources
    input  wire logic        slow_clk_in,
    input  wire logic        backup_rst_in,
    input  wire logic        wdog_fault_in,
    // external reset pin
    input  wire logic        pin_in,
    output logic             pin_out,
    output logic             pin_oe_out,
    // reset lines and interrupt
    output logic             cpu_rst_out,
    output logic             periph_rst_out,
    output logic             irq_out
);

    typedef struct packed {
        rstc_state_t st;
        logic [1:0]  ticks;
        logic        busy;
        logic        cpu_rst;
        logic        per_rst;
        logic        sw_cpu;
        logic [2:0]  cause;
        logic [2:0]  pend;
        logic        edge_flag;
        logic        pen;
        logic        pien;
        logic [3:0]  len;
        logic [1:0]  irq_sts;
        logic [1:0]  irq_msk;
        logic [31:0] rd_data;
        logic        irq;
        logic        slow_prev;
        logic        pin_prev;
        logic        suppress;
        logic        pulse_go;
        logic        pin_oe;
        logic        pin_val;
    } rstc_regs_t;

    rstc_regs_t q, d;
    logic [1:0] sync_s;
    logic       slow_s;
    logic       pin_s;
    logic       pulse_act;
    logic       tick;
    logic       fall;
    logic       key_ok;
    logic       cmd_ok;
    logic       cmd_any;

    ////////////////////////////////////////////////////////////////////
    // synchronisers and pin pulse timer

    // pin idles high, so its synchroniser resets high
    rstc_sync #(.WIDTH(2), .RST_VAL(2'h2)) u_sync (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .async_in    ({pin_in, slow_clk_in}),
        .sync_out    (sync_s)
    );

    assign slow_s = sync_s[0];
    assign pin_s  = sync_s[1];

    rstc_pulse u_pulse (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .go_in       (q.pulse_go),
        .tick_in     (tick),
        .len_in      (q.len),
        .active_out  (pulse_act)
    );

    ////////////////////////////////////////////////////////////////////
    // next state

    assign tick    = slow_s && !q.slow_prev;
    assign fall    = q.pin_prev && !pin_s;
    assign key_ok  = wr_data_in[RSTC_KEY_LSB +: 8] == RSTC_KEY_VAL;
    assign cmd_any = wr_data_in[RSTC_CPU_BIT] || wr_data_in[RSTC_PER_BIT]
                     || wr_data_in[RSTC_PIN_BIT];
    // busy or mid-reset commands vanish silently
    assign cmd_ok  = wr_in && addr_in == RSTC_CMD_OFS && key_ok
                     && !q.busy && q.st == ST_IDLE;

    always_comb begin
        d           = q;
        d.rd_data   = '0;
        d.pulse_go  = 1'b0;
        d.slow_prev = slow_s;
        d.pin_prev  = pin_s;
        d.pin_val   = 1'b0;
        d.pin_oe    = pulse_act;
        // mode write, reserved bits dropped
        if (wr_in && addr_in == RSTC_MODE_OFS && key_ok) begin
            d.pen  = wr_data_in[RSTC_PEN_BIT];
            d.pien = wr_data_in[RSTC_PIEN_BIT];
            d.len  = wr_data_in[RSTC_LEN_LSB +: 4];
        end
        if (wr_in && addr_in == RSTC_IRQ_MSK_OFS) begin
            d.irq_msk = wr_data_in[1:0];
        end
        if (wr_in && addr_in == RSTC_IRQ_STS_OFS) begin
            d.irq_sts = q.irq_sts & ~wr_data_in[1:0];
        end
        // software command
        if (cmd_ok && cmd_any) begin
            d.st       = ST_SW;
            d.ticks    = '0;
            d.busy     = 1'b1;
            d.cpu_rst  = wr_data_in[RSTC_CPU_BIT];
            d.per_rst  = wr_data_in[RSTC_PER_BIT];
            d.sw_cpu   = wr_data_in[RSTC_CPU_BIT];
            d.pulse_go = wr_data_in[RSTC_PIN_BIT];
            if (wr_data_in[RSTC_PIN_BIT]) begin
                d.suppress = 1'b1;
            end
        end
        // own pulse must not look like a user reset
        if (q.suppress && !pulse_act && !q.pulse_go && pin_s) begin
            d.suppress = 1'b0;
        end
        unique case (q.st)
            ST_IDLE: begin
                if (q.pen && !pin_s && !q.suppress && !cmd_ok) begin
                    d.st      = ST_USER;
                    d.ticks   = '0;
                    d.cpu_rst = 1'b1;
                    d.per_rst = 1'b1;
                end
            end
            ST_SW: begin
                if (tick) begin
                    d.ticks = 2'(q.ticks + 2'h1);
                    if (2'(q.ticks + 2'h1) == RSTC_HOLD_TICKS) begin
                        d.st      = ST_IDLE;
                        d.busy    = 1'b0;
                        d.cpu_rst = 1'b0;
                        d.per_rst = 1'b0;
                        d.irq_sts[RSTC_IRQ_DONE] = 1'b1;
                        if (q.sw_cpu) begin
                            d.cause = RSTC_CAUSE_SW;
                        end
                    end
                end
            end
            ST_USER, ST_HW: begin
                // held while pin low or backup asserted, then startup
                if ((q.st == ST_USER && !pin_s) ||
                    (q.st == ST_HW && backup_rst_in)) begin
                    d.ticks = '0;
                end else if (tick) begin
                    d.ticks = 2'(q.ticks + 2'h1);
                    if (2'(q.ticks + 2'h1) == RSTC_HOLD_TICKS) begin
                        d.st      = ST_IDLE;
                        d.cpu_rst = 1'b0;
                        d.per_rst = 1'b0;
                        d.cause   = (q.st == ST_USER) ? RSTC_CAUSE_USER
                                                      : q.pend;
                    end
                end
            end
        endcase
        // hardware sources outrank software and user resets
        if (backup_rst_in || (wdog_fault_in && q.st != ST_HW)) begin
            d.st      = ST_HW;
            d.pend    = backup_rst_in ? RSTC_CAUSE_BKUP
                                      : RSTC_CAUSE_WDOG;
            d.ticks   = '0;
            d.busy    = 1'b0;
            d.cpu_rst = 1'b1;
            d.per_rst = 1'b1;
        end
        // edge flag: read clears, a new edge in that cycle wins
        if (rd_in && addr_in == RSTC_STS_OFS) begin
            d.edge_flag = 1'b0;
        end
        if (fall) begin
            d.edge_flag = 1'b1;
            d.irq_sts[RSTC_IRQ_EDGE] = 1'b1;
        end
        d.irq = (d.edge_flag && d.pien && !d.pen)
                || |(d.irq_sts & d.irq_msk);
        // read data, valid only in the cycle after the strobe
        if (rd_in) begin
            unique case (addr_in)
                RSTC_STS_OFS: begin
                    d.rd_data[RSTC_EDGE_BIT]       = q.edge_flag;
                    d.rd_data[RSTC_CAUSE_LSB +: 3] = q.cause;
                    d.rd_data[RSTC_LEVEL_BIT]      = pin_s;
                    d.rd_data[RSTC_BUSY_BIT]       = q.busy;
                end
                RSTC_MODE_OFS: begin
                    d.rd_data[RSTC_PEN_BIT]      = q.pen;
                    d.rd_data[RSTC_PIEN_BIT]     = q.pien;
                    d.rd_data[RSTC_LEN_LSB +: 4] = q.len;
                end
                RSTC_IRQ_STS_OFS: d.rd_data[1:0] = q.irq_sts;
                RSTC_IRQ_MSK_OFS: d.rd_data[1:0] = q.irq_msk;
                default: d.rd_data = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            q          <= '0;
            q.st       <= ST_IDLE;
            q.cause    <= RSTC_CAUSE_GEN;
            q.pen      <= RSTC_PEN_RST;
            q.pien     <= RSTC_PIEN_RST;
            q.len      <= RSTC_LEN_RST;
            q.pin_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign rd_data_out    = q.rd_data;
    assign pin_out        = q.pin_val;
    assign pin_oe_out     = q.pin_oe;
    assign cpu_rst_out    = q.cpu_rst;
    assign periph_rst_out = q.per_rst;
    assign irq_out        = q.irq;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    logic cmd_wr;
    assign cmd_wr = wr_in && addr_in == RSTC_CMD_OFS && !backup_rst_in
                    && !wdog_fault_in;

    property p_bad_key;
        cmd_wr && !key_ok && q.st == ST_IDLE |=> !q.busy;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("command with wrong password was taken");

    property p_cpu_cmd;
        // a hardware source in the same cycle clears busy, so leave it out
        cmd_ok && wr_data_in[RSTC_CPU_BIT] && !backup_rst_in && !wdog_fault_in
        |=> cpu_rst_out && q.busy;
    endproperty
    a_cpu_cmd: assert property (p_cpu_cmd)
        else $error("cpu reset command did not reset processor");

    property p_per_cmd;
        cmd_ok && wr_data_in[RSTC_PER_BIT] |=> periph_rst_out;
    endproperty
    a_per_cmd: assert property (p_per_cmd)
        else $error("peripheral reset command had no effect");

    property p_pin_cmd;
        cmd_ok && wr_data_in[RSTC_PIN_BIT] |-> ##[2:3] pin_oe_out && !pin_out;
    endproperty
    a_pin_cmd: assert property (p_pin_cmd)
        else $error("pin reset command did not drive pin low");

    property p_edge_set;
        fall |=> q.edge_flag;
    endproperty
    a_edge_set: assert property (p_edge_set)
        else $error("falling pin edge not flagged");

    property p_cause_hold;
        q.st == ST_IDLE && !cmd_wr ##0 rd_in |=> $stable(q.cause);
    endproperty
    a_cause_hold: assert property (p_cause_hold)
        else $error("reset cause changed without a reset");

    property p_level;
        rd_in && addr_in == RSTC_STS_OFS
        |=> rd_data_out[RSTC_LEVEL_BIT] == $past(pin_s);
    endproperty
    a_level: assert property (p_level)
        else $error("pin level bit wrong");

    property p_sw_len;
        $fell(q.busy) && q.st == ST_IDLE |-> $past(q.ticks) == 2'h2;
    endproperty
    a_sw_len: assert property (p_sw_len)
        else $error("software reset length wrong");

    property p_busy_ignore;
        q.busy && cmd_wr && key_ok && !cpu_rst_out && !tick
        |=> !cpu_rst_out;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore)
        else $error("command taken while busy");

    property p_irq;
        d.edge_flag && d.pien && !d.pen |=> irq_out;
    endproperty
    a_irq: assert property (p_irq)
        else $error("edge interrupt missing");

    property p_rd_clear;
        rd_in && addr_in == RSTC_STS_OFS && !fall |=> !q.edge_flag;
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("status read did not clear edge flag");

    c_sw_reset: cover property ($fell(q.busy));
    c_user_reset: cover property (q.st == ST_USER ##1 q.st == ST_IDLE);
    c_edge_irq: cover property ($rose(irq_out));
    c_wdog: cover property (q.st == ST_HW && q.pend == RSTC_CAUSE_WDOG);

endmodule : rstc_regs
`default_nettype wire

// >>> verilog/rstc_sync.sv
// rstc_sync: two-flop synchroniser for asynchronous levels
// assumes inputs are quasi-static against core_clk_in
`timescale 1ns/10ps
`default_nettype none
module rstc_sync #(
    parameter int               WIDTH   = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             sys_rst_in,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } rstc_sync_t;

    rstc_sync_t q, d;

    // first stage feeds only the second
    always_comb begin
        d    = q;
        d.s1 = async_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            q <= '{s1: RST_VAL, s2: RST_VAL};
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.s2;

endmodule : rstc_sync
`default_nettype wire
